// ===== verilog/cpa_drive.sv
`timescale 1ns/1ps
module cpa_drive #(
	parameter int NPARAM   = 256,
	parameter int NCAM     = 257,
	parameter int PROG_LEN = 256,
	parameter logic [15:0] NODE_RESET = 16'h0001,
	parameter logic [31:0] DEV_TYPE   = 32'h00000000, // arbitrary
	parameter logic [31:0] IDENT      = 32'h0000A5A5  // arbitrary
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// Master link
	cpa_if.drive      bus,
	// Drive-side view of parameters
	input  wire logic [7:0]  prm_idx,
	output logic      [15:0] prm_value,
	output logic      [6:0]  node_addr
);
	typedef struct packed {
		logic [NPARAM-1:0][15:0]   prm;
		logic [NCAM-1:0][15:0]     cam;
		logic [PROG_LEN-1:0][7:0]  prog;
		logic                      rep_valid;
		logic [63:0]               rep_data;
		logic                      sdo_done;
		logic [1:0]                sdo_status;
		logic [31:0]               sdo_rdata;
	} cpa_drv_t;

	cpa_drv_t st_reg, st_next;

	function automatic logic [15:0] apply_op(input logic [4:0] op, input logic [15:0] old, input logic [15:0] m);
		case (op)
			cpa_pkg::CMD_WRITE:  apply_op = m;
			cpa_pkg::CMD_SET:    apply_op = old | m;
			cpa_pkg::CMD_RESET:  apply_op = old & ~m;
			cpa_pkg::CMD_TOGGLE: apply_op = old ^ m;
			default:             apply_op = old;
		endcase
	endfunction

	logic [4:0]  rq_cmd;
	logic [2:0]  rq_len;
	logic [15:0] rq_addr;
	logic [31:0] rq_dat;
	logic [6:0]  my_node;
	logic        rq_hit;
	int          pi;
	int          sidx;

	// Byte 0 command & length, bytes 1-2 address, bytes 3-6 data, low byte first
	assign rq_cmd  = bus.req_data[cpa_pkg::CMD_LSB +: 5];
	assign rq_len  = bus.req_data[cpa_pkg::LEN_LSB +: 3];
	assign rq_addr = bus.req_data[23:8];
	assign rq_dat  = bus.req_data[55:24];
	assign my_node = st_reg.prm[cpa_pkg::NODE_PARAM][6:0];
	assign rq_hit  = bus.req_valid && bus.req_id[10:7] == cpa_pkg::FN_PDO2_REQ
		&& bus.req_id[6:0] == my_node && my_node != 7'h00;

	always_comb begin
		logic [31:0] m;
		logic [15:0] rd;
		logic [15:0] rd_hi;
		m     = 32'h00000000;
		rd    = 16'h0000;
		rd_hi = 16'h0000;
		pi    = 0;
		sidx  = 0;
		st_next = st_reg;
		st_next.rep_valid = 1'b0;
		st_next.sdo_done  = 1'b0;
		// Mask data beyond the significant length
		for (int b = 0; b < 4; b++) begin
			if (b < int'(rq_len))
				m[b*8 +: 8] = rq_dat[b*8 +: 8];
		end
		if (rq_hit && rq_len <= cpa_pkg::LEN_MAX && rq_cmd <= cpa_pkg::CMD_TOGGLE) begin
			if (rq_addr >= cpa_pkg::PROG_LO && rq_addr <= cpa_pkg::PROG_HI) begin
				pi = int'(rq_addr - cpa_pkg::PROG_LO);
				rd = {8'h00, st_reg.prog[pi]};
				if (rq_cmd != cpa_pkg::CMD_READ)
					for (int b = 0; b < 4; b++)
						if (b < int'(rq_len) && pi + b < PROG_LEN)
							st_next.prog[pi+b] = m[b*8 +: 8];
			end else if (rq_addr >= cpa_pkg::CAM_LO && rq_addr <= cpa_pkg::CAM_HI) begin
				pi = int'(rq_addr - cpa_pkg::CAM_LO) >> 1;
				if (pi < NCAM) begin
					rd = st_reg.cam[pi];
					st_next.cam[pi] = apply_op(rq_cmd, st_reg.cam[pi], m[15:0]);
				end
			end else begin
				pi = int'(rq_addr >> 1);
				if (pi < NPARAM) begin
					rd = st_reg.prm[pi];
					st_next.prm[pi] = apply_op(rq_cmd, st_reg.prm[pi], m[15:0]);
					if (rq_cmd != cpa_pkg::CMD_READ && rq_len > 3'h2 && pi + 1 < NPARAM)
						st_next.prm[pi+1] = apply_op(rq_cmd, st_reg.prm[pi+1], m[31:16]);
					if (pi + 1 < NPARAM)
						rd_hi = st_reg.prm[pi+1];
				end
			end
			if (rq_cmd == cpa_pkg::CMD_READ) begin
				st_next.rep_valid = 1'b1;
				// Header, address, data; the eighth byte is spare and sent as zero
				st_next.rep_data = {8'h00, rd_hi, rd, rq_addr, st_reg.prm[cpa_pkg::HDR_PARAM][7:0]};
			end
		end
		if (bus.sdo_valid) begin
			st_next.sdo_done   = 1'b1;
			st_next.sdo_status = cpa_pkg::SDO_OK;
			st_next.sdo_rdata  = 32'h00000000;
			sidx = int'(bus.sdo_sub) - 1;
			m = bus.sdo_wdata;
			case (bus.sdo_index)
				cpa_pkg::OBJ_DEV_TYPE, cpa_pkg::OBJ_ERR_REG, cpa_pkg::OBJ_GUARD, cpa_pkg::OBJ_LIFE,
				cpa_pkg::OBJ_EMCY_ID, cpa_pkg::OBJ_IDENT, cpa_pkg::OBJ_SDO_SRV: begin
					if (bus.sdo_write)
						st_next.sdo_status = cpa_pkg::SDO_RO;
					else if (bus.sdo_index == cpa_pkg::OBJ_DEV_TYPE)
						st_next.sdo_rdata = DEV_TYPE;
					else if (bus.sdo_index == cpa_pkg::OBJ_IDENT)
						st_next.sdo_rdata = IDENT;
					else if (bus.sdo_index == cpa_pkg::OBJ_EMCY_ID)
						st_next.sdo_rdata = {25'h0, my_node} + 32'h00000080;
					else if (bus.sdo_index == cpa_pkg::OBJ_SDO_SRV)
						st_next.sdo_rdata = {25'h0, my_node} + 32'h00000600;
				end
				cpa_pkg::OBJ_PARAM, cpa_pkg::OBJ_PSET, cpa_pkg::OBJ_PRST: begin
					if (bus.sdo_sub == 8'h00) begin
						if (bus.sdo_write)
							st_next.sdo_status = cpa_pkg::SDO_RO;
						else
							st_next.sdo_rdata = NPARAM;
					end else if (sidx >= NPARAM) begin
						st_next.sdo_status = cpa_pkg::SDO_NOOBJ;
					end else if (!bus.sdo_write) begin
						st_next.sdo_rdata[15:0] = st_reg.prm[sidx];
						if (sidx + 1 < NPARAM)
							st_next.sdo_rdata[31:16] = st_reg.prm[sidx+1];
					end else begin
						for (int h = 0; h < 2; h++) begin
							if ((h == 0 || bus.sdo_len > 3'h2) && sidx + h < NPARAM) begin
								if (bus.sdo_index == cpa_pkg::OBJ_PSET)
									st_next.prm[sidx+h] = st_reg.prm[sidx+h] | m[h*16 +: 16];
								else if (bus.sdo_index == cpa_pkg::OBJ_PRST)
									st_next.prm[sidx+h] = st_reg.prm[sidx+h] & ~m[h*16 +: 16];
								else
									st_next.prm[sidx+h] = m[h*16 +: 16];
							end
						end
					end
				end
				cpa_pkg::OBJ_PROG: begin
					if (bus.sdo_sub == 8'h00 || sidx >= PROG_LEN) begin
						st_next.sdo_status = cpa_pkg::SDO_NOOBJ;
					end else begin
						for (int b = 0; b < 4; b++) begin
							if (sidx + b < PROG_LEN) begin
								if (!bus.sdo_write)
									st_next.sdo_rdata[b*8 +: 8] = st_reg.prog[sidx+b];
								else if (b < int'(bus.sdo_len))
									st_next.prog[sidx+b] = m[b*8 +: 8];
							end
						end
					end
				end
				cpa_pkg::OBJ_CAM1, cpa_pkg::OBJ_CAM2: begin
					if (bus.sdo_index == cpa_pkg::OBJ_CAM2)
						sidx = sidx + int'(cpa_pkg::CAM2_BASE);
					if (bus.sdo_sub == 8'h00 || sidx >= NCAM
						|| (bus.sdo_index == cpa_pkg::OBJ_CAM1 && sidx >= int'(cpa_pkg::CAM2_BASE))) begin
						st_next.sdo_status = cpa_pkg::SDO_NOOBJ;
					end else if (bus.sdo_write) begin
						st_next.cam[sidx] = m[15:0];
					end else begin
						st_next.sdo_rdata[15:0] = st_reg.cam[sidx];
					end
				end
				default: st_next.sdo_status = cpa_pkg::SDO_NOOBJ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.prm[cpa_pkg::NODE_PARAM] <= NODE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus.rep_valid  = st_reg.rep_valid;
	assign bus.rep_id     = {cpa_pkg::FN_PDO2_REPLY, my_node};
	assign bus.rep_data   = st_reg.rep_data;
	assign bus.sdo_done   = st_reg.sdo_done;
	assign bus.sdo_status = st_reg.sdo_status;
	assign bus.sdo_rdata  = st_reg.sdo_rdata;
	assign prm_value      = st_reg.prm[prm_idx];
	assign node_addr      = my_node;
endmodule

// ===== inc/cpa_pkg.sv
package cpa_pkg;
	// Frame identifier function codes and node address range
	localparam logic [3:0]  FN_PDO2_REQ    = 4'h6;
	localparam logic [3:0]  FN_PDO2_REPLY  = 4'h5;
	localparam logic [6:0]  NODE_MIN       = 7'h01;
	localparam logic [6:0]  NODE_MAX       = 7'h7F;
	// Request and reply layout
	localparam int          REQ_BYTES      = 7;
	localparam int          REPLY_BYTES    = 8;
	localparam int          CMD_LSB        = 0;
	localparam int          LEN_LSB        = 5;
	localparam logic [2:0]  LEN_MAX        = 3'h4;
	// Commands
	localparam logic [4:0]  CMD_READ       = 5'h00;
	localparam logic [4:0]  CMD_WRITE      = 5'h01;
	localparam logic [4:0]  CMD_SET        = 5'h02;
	localparam logic [4:0]  CMD_RESET      = 5'h03;
	localparam logic [4:0]  CMD_TOGGLE     = 5'h04;
	// Address windows
	localparam logic [15:0] CAM_LO         = 16'h1000;
	localparam logic [15:0] CAM_HI         = 16'h1200;
	localparam logic [15:0] PROG_LO        = 16'h2000;
	localparam logic [15:0] PROG_HI        = 16'h20FF;
	// Dictionary indexes
	localparam logic [15:0] OBJ_DEV_TYPE   = 16'h1000;
	localparam logic [15:0] OBJ_ERR_REG    = 16'h1001;
	localparam logic [15:0] OBJ_GUARD      = 16'h100C;
	localparam logic [15:0] OBJ_LIFE       = 16'h100D;
	localparam logic [15:0] OBJ_EMCY_ID    = 16'h1014;
	localparam logic [15:0] OBJ_IDENT      = 16'h1018;
	localparam logic [15:0] OBJ_SDO_SRV    = 16'h1200;
	localparam logic [15:0] OBJ_PARAM      = 16'h2000;
	localparam logic [15:0] OBJ_PSET       = 16'h2001;
	localparam logic [15:0] OBJ_PRST       = 16'h2002;
	localparam logic [15:0] OBJ_PROG       = 16'h2003;
	localparam logic [15:0] OBJ_CAM1       = 16'h2004;
	localparam logic [15:0] OBJ_CAM2       = 16'h2005;
	localparam logic [7:0]  CAM2_BASE      = 8'hFF;
	// Fixed parameter numbers
	localparam int          NODE_PARAM     = 49;
	localparam int          HDR_PARAM      = 27;
	// Service-data status answers
	localparam logic [1:0]  SDO_OK         = 2'h0;
	localparam logic [1:0]  SDO_RO         = 2'h1;
	localparam logic [1:0]  SDO_NOOBJ      = 2'h2;
endpackage

// ===== inc/cpa_if.sv
`timescale 1ns/1ps
interface cpa_if;
	// Process-data request, master to drive
	logic        req_valid;
	logic [10:0] req_id;
	logic [55:0] req_data;
	// Process-data reply, drive to master
	logic        rep_valid;
	logic [10:0] rep_id;
	logic [63:0] rep_data;
	// Service-data access
	logic        sdo_valid;
	logic        sdo_write;
	logic [15:0] sdo_index;
	logic [7:0]  sdo_sub;
	logic [2:0]  sdo_len;
	logic [31:0] sdo_wdata;
	logic        sdo_done;
	logic [1:0]  sdo_status;
	logic [31:0] sdo_rdata;

	modport drive (
		input  req_valid, req_id, req_data, sdo_valid, sdo_write, sdo_index, sdo_sub, sdo_len, sdo_wdata,
		output rep_valid, rep_id, rep_data, sdo_done, sdo_status, sdo_rdata
	);
	modport master (
		output req_valid, req_id, req_data, sdo_valid, sdo_write, sdo_index, sdo_sub, sdo_len, sdo_wdata,
		input  rep_valid, rep_id, rep_data, sdo_done, sdo_status, sdo_rdata
	);
endinterface

// ===== verilog/cpa_master.sv
`timescale 1ns/1ps
module cpa_master (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// Drive link
	cpa_if.master     bus,
	// User request
	input  wire logic        usr_go,
	input  wire logic [6:0]  usr_node,
	input  wire logic [4:0]  usr_cmd,
	input  wire logic [2:0]  usr_len,
	input  wire logic [15:0] usr_param,
	input  wire logic [31:0] usr_data,
	output logic             usr_busy,
	// User answer
	output logic             usr_rvalid,
	output logic [31:0]      usr_rdata
);
	typedef enum logic [1:0] {M_IDLE = 2'b00, M_SEND = 2'b01, M_WAIT = 2'b11} cpa_mst_st_t;
	typedef struct packed {
		cpa_mst_st_t st;
		logic        req_valid;
		logic [10:0] req_id;
		logic [55:0] req_data;
		logic [6:0]  node;
		logic        rvalid;
		logic [31:0] rdata;
	} cpa_mst_t;

	cpa_mst_t s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		s_next.req_valid = 1'b0;
		s_next.rvalid = 1'b0;
		case (s_reg.st)
			M_IDLE: begin
				// Node 0 is not a drive address
				if (usr_go && usr_node != 7'h00 && usr_len <= cpa_pkg::LEN_MAX) begin
					s_next.req_valid = 1'b1;
					s_next.node      = usr_node;
					s_next.req_id    = {cpa_pkg::FN_PDO2_REQ, usr_node};
					s_next.req_data  = {usr_data, usr_param[14:0], 1'b0, usr_len, usr_cmd};
					s_next.st        = M_SEND;
				end
			end
			M_SEND: s_next.st = (s_reg.req_data[4:0] == cpa_pkg::CMD_READ) ? M_WAIT : M_IDLE;
			M_WAIT: begin
				// Reply must come from the addressed node
				if (bus.rep_valid && bus.rep_id == {cpa_pkg::FN_PDO2_REPLY, s_reg.node}) begin
					s_next.rvalid = 1'b1;
					// Reply data sits above the address, below the spare byte
					s_next.rdata  = bus.rep_data[55:24];
					s_next.st     = M_IDLE;
				end
			end
			default: s_next.st = M_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign bus.req_valid = s_reg.req_valid;
	assign bus.req_id    = s_reg.req_id;
	assign bus.req_data  = s_reg.req_data;
	assign bus.sdo_valid = 1'b0;
	assign bus.sdo_write = 1'b0;
	assign bus.sdo_index = 16'h0000;
	assign bus.sdo_sub   = 8'h00;
	assign bus.sdo_len   = 3'h0;
	assign bus.sdo_wdata = 32'h00000000;
	assign usr_busy      = s_reg.st != M_IDLE;
	assign usr_rvalid    = s_reg.rvalid;
	assign usr_rdata     = s_reg.rdata;
endmodule

// ===== test/cpa_chk.sv
`timescale 1ns/1ps
module cpa_chk (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rstn,
	// Request
	input wire logic        req_valid,
	input wire logic [10:0] req_id,
	input wire logic [55:0] req_data,
	// Reply
	input wire logic        rep_valid,
	input wire logic [10:0] rep_id,
	input wire logic [63:0] rep_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_good_id;
		req_valid && req_id[10:7] == cpa_pkg::FN_PDO2_REQ && req_id[6:0] == rep_id[6:0];
	endsequence
	sequence s_read_req;
		s_good_id ##0 (req_data[4:0] == cpa_pkg::CMD_READ && req_data[7:5] <= cpa_pkg::LEN_MAX);
	endsequence
	a_read_reply: assert property (s_read_req |=> rep_valid) else $error("read got no reply");
	a_reply_addr: assert property (s_read_req |=> rep_data[23:8] == $past(req_data[23:8]))
		else $error("reply address differs");
	a_reply_cause: assert property (rep_valid |-> $past(req_valid) && $past(req_data[4:0]) == 5'h00)
		else $error("reply without read");
	a_no_reply_cmd: assert property (req_valid && req_data[4:0] != 5'h00 |=> !rep_valid)
		else $error("reply to non-read");
	a_no_reply_len: assert property (req_valid && req_data[7:5] > cpa_pkg::LEN_MAX |=> !rep_valid)
		else $error("reply to bad length");
	a_no_reply_node: assert property (req_valid && req_id[6:0] != rep_id[6:0] |=> !rep_valid)
		else $error("reply to other node");
	a_rep_id_ok: assert property (rep_id[10:7] == cpa_pkg::FN_PDO2_REPLY && rep_id[6:0] != 7'h00)
		else $error("bad reply id");
	a_req_func_ok: assert property (req_valid |-> req_id[10:7] == cpa_pkg::FN_PDO2_REQ)
		else $error("bad request id");
	a_addr_even: assert property (req_valid |-> !req_data[8]) else $error("odd address");
	a_data_hold: assert property (!rep_valid |-> $stable(rep_data)) else $error("reply data moved");
endmodule

// ===== test/test_canopen_param_access.sv
`timescale 1ns/1ps
module test_canopen_param_access;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        usr_go = 1'b0;
	logic [6:0]  usr_node = 7'h01;
	logic [4:0]  usr_cmd = 5'h00;
	logic [2:0]  usr_len = 3'h0;
	logic [15:0] usr_param = 16'h0000;
	logic [31:0] usr_data = 32'h0;
	logic        usr_busy, usr_rvalid;
	logic [31:0] usr_rdata, rd;
	logic [7:0]  prm_idx = 8'h00;
	logic [15:0] prm_value, prm_value_b;
	logic [6:0]  node_addr;
	logic [1:0]  st;
	int          err_count = 0;
	int          checks = 0;
	int          cycles = 0;
	cpa_if bus_a();
	cpa_if bus_b();
	cpa_drive i_cpa_drive (.mclk(mclk), .rstn(rstn), .bus(bus_a), .prm_idx(prm_idx), .prm_value(prm_value),
		.node_addr(node_addr));
	cpa_drive i_cpa_drive_b (.mclk(mclk), .rstn(rstn), .bus(bus_b), .prm_idx(prm_idx), .prm_value(prm_value_b),
		.node_addr());
	cpa_master i_cpa_master (.mclk(mclk), .rstn(rstn), .bus(bus_a), .usr_go(usr_go), .usr_node(usr_node),
		.usr_cmd(usr_cmd), .usr_len(usr_len), .usr_param(usr_param), .usr_data(usr_data), .usr_busy(usr_busy),
		.usr_rvalid(usr_rvalid), .usr_rdata(usr_rdata));
	cpa_chk i_cpa_chk (.mclk(mclk), .rstn(rstn), .req_valid(bus_a.req_valid), .req_id(bus_a.req_id),
		.req_data(bus_a.req_data), .rep_valid(bus_a.rep_valid), .rep_id(bus_a.rep_id), .rep_data(bus_a.rep_data));
	always #5 mclk = ~mclk;
	initial begin
		{bus_b.req_valid, bus_b.req_id, bus_b.req_data} = '0;
		{bus_b.sdo_valid, bus_b.sdo_write, bus_b.sdo_index, bus_b.sdo_sub, bus_b.sdo_len, bus_b.sdo_wdata} = '0;
	end
	task automatic stop_test();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Master-side request; rd keeps any read answer
	task automatic pdo(logic [4:0] c, logic [2:0] l, logic [15:0] p, logic [31:0] d, logic [6:0] n = 7'h01);
		@(negedge mclk);
		{usr_cmd, usr_len, usr_param, usr_data, usr_node, usr_go} = {c, l, p, d, n, 1'b1};
		@(negedge mclk);
		usr_go = 1'b0;
		for (int k = 0; k < 30; k++) begin
			@(negedge mclk);
			if (usr_rvalid === 1'b1)
				rd = usr_rdata;
			if (usr_busy === 1'b0)
				break;
		end
	endtask
	task automatic prm(logic [7:0] i, logic [15:0] exp);
		@(negedge mclk);
		prm_idx = i;
		#1 cmp("prm_value", {16'h0, exp}, {16'h0, prm_value});
	endtask
	// Service-data access on the second link
	task automatic sdo(logic w, logic [15:0] ix, logic [7:0] sb, logic [2:0] l, logic [31:0] d);
		@(negedge mclk);
		{bus_b.sdo_write, bus_b.sdo_index, bus_b.sdo_sub, bus_b.sdo_len, bus_b.sdo_wdata} = {w, ix, sb, l, d};
		bus_b.sdo_valid = 1'b1;
		@(negedge mclk);
		bus_b.sdo_valid = 1'b0;
		for (int k = 0; k < 5 && bus_b.sdo_done !== 1'b1; k++)
			@(negedge mclk);
		{st, rd} = {bus_b.sdo_status, bus_b.sdo_rdata};
	endtask
	// Raw request on the second link; returns while any reply still stands
	task automatic raw(logic [4:0] c, logic [2:0] l, logic [15:0] a, logic [31:0] d);
		@(negedge mclk);
		bus_b.req_id    = {cpa_pkg::FN_PDO2_REQ, 7'h01};
		bus_b.req_data  = {d, a, l, c};
		bus_b.req_valid = 1'b1;
		@(negedge mclk);
		bus_b.req_valid = 1'b0;
	endtask
	task automatic t_raw();
		raw(5'h01, 3'h5, 16'd80, 32'hFFFF);
		cmp("len write reply", 32'd0, {31'h0, bus_b.rep_valid});
		prm_idx = 8'd40;
		#1 cmp("prm b", 32'd0, {16'h0, prm_value_b});
		raw(5'h00, 3'h5, 16'd120, 32'h0);
		cmp("len read reply", 32'd0, {31'h0, bus_b.rep_valid});
		raw(5'h05, 3'h0, 16'd120, 32'h0);
		cmp("unused cmd reply", 32'd0, {31'h0, bus_b.rep_valid});
		raw(5'h00, 3'h0, 16'd120, 32'h0);
		cmp("reply valid", 32'd1, {31'h0, bus_b.rep_valid});
		cmp("reply data", 32'hAAAA5552, bus_b.rep_data[55:24]);
		cmp("reply addr", 32'h00000078, {16'h0, bus_b.rep_data[23:8]});
		cmp("reply id", {21'h0, 4'h5, 7'h01}, {21'h0, bus_b.rep_id});
	endtask
	task automatic t_spill();
		pdo(5'h01, 3'h4, 16'd80, 32'h12345678);
		prm(8'd80, 16'h5678);
		prm(8'd81, 16'h1234);
		pdo(5'h00, 3'h0, 16'd80, 32'h0);
		cmp("read pdo", 32'h12345678, rd);
	endtask
	task automatic t_bits();
		pdo(5'h01, 3'h2, 16'd40, 32'h00F0);
		pdo(5'h02, 3'h2, 16'd40, 32'h000F);
		prm(8'd40, 16'h00FF);
		pdo(5'h03, 3'h2, 16'd40, 32'h0030);
		prm(8'd40, 16'h00CF);
		pdo(5'h04, 3'h2, 16'd40, 32'h0101);
		prm(8'd40, 16'h01CE);
	endtask
	task automatic t_refuse();
		pdo(5'h05, 3'h2, 16'd40, 32'hFFFF);
		pdo(5'h1F, 3'h2, 16'd40, 32'hFFFF);
		prm(8'd40, 16'h01CE);
		pdo(5'h01, 3'h5, 16'd40, 32'hFFFF);
		prm(8'd40, 16'h01CE);
		pdo(5'h01, 3'h2, 16'd40, 32'hFFFF, 7'h02);
		prm(8'd40, 16'h01CE);
	endtask
	task automatic t_cam();
		pdo(5'h01, 3'h2, 16'd2048, 32'hBEEF);
		pdo(5'h00, 3'h0, 16'd2048, 32'h0);
		cmp("cam pdo", 32'hBEEF, {16'h0, rd[15:0]});
		pdo(5'h01, 3'h4, 16'd4096, 32'h11223344);
		pdo(5'h00, 3'h0, 16'd4097, 32'h0);
		cmp("program pdo", 32'h00000022, rd);
		cmp("node", 32'd1, {25'h0, node_addr});
	endtask
	task automatic t_sdo();
		logic [15:0] ro[7] = '{16'h1000, 16'h1001, 16'h100C, 16'h100D, 16'h1014, 16'h1018, 16'h1200};
		sdo(1'b0, 16'h2000, 8'h00, 3'h0, 32'h0);
		cmp("count", 32'd256, rd);
		sdo(1'b1, 16'h2000, 8'h3D, 3'h4, 32'hAAAA5555);
		sdo(1'b1, 16'h2001, 8'h3D, 3'h2, 32'h0002);
		sdo(1'b1, 16'h2002, 8'h3D, 3'h2, 32'h0005);
		sdo(1'b0, 16'h2000, 8'h3D, 3'h0, 32'h0);
		cmp("param sdo", 32'hAAAA5552, rd);
		sdo(1'b1, 16'h2003, 8'h01, 3'h2, 32'h5A00);
		sdo(1'b0, 16'h2003, 8'h01, 3'h0, 32'h0);
		cmp("program", 32'h00005A00, rd);
		sdo(1'b1, 16'h2005, 8'h01, 3'h2, 32'h1234);
		sdo(1'b0, 16'h2005, 8'h01, 3'h0, 32'h0);
		cmp("cam sdo", 32'h1234, {16'h0, rd[15:0]});
		sdo(1'b0, 16'h2005, 8'h03, 3'h0, 32'h0);
		cmp("cam range", 32'd2, {30'h0, st});
		sdo(1'b0, 16'h1014, 8'h00, 3'h0, 32'h0);
		cmp("emcy id", 32'h00000081, rd);
		sdo(1'b0, 16'h1200, 8'h00, 3'h0, 32'h0);
		cmp("server id", 32'h00000601, rd);
		foreach (ro[i]) begin
			sdo(1'b1, ro[i], 8'h00, 3'h4, 32'hFFFFFFFF);
			cmp("ro status", 32'd1, {30'h0, st});
		end
		sdo(1'b0, 16'h3000, 8'h00, 3'h0, 32'h0);
		cmp("no object", 32'd2, {30'h0, st});
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		rstn = 1'b1;
		t_spill();
		t_bits();
		t_refuse();
		t_cam();
		t_sdo();
		t_raw();
		stop_test();
	end
endmodule
